//--- hw/goto_entry.sv
`timescale 1ns/1ns
module goto_entry import loop_cfg_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic enable_i,
	input wire logic [3:0] digit_i,
	input wire logic push_i,
	input wire logic clear_i,
	input wire logic confirm_i,
	input wire logic [6:0] count_i,
	output logic [1:0] digits_o,
	output logic sel_valid_o,
	output logic [6:0] sel_o
);
	logic [11:0] val;
	logic [9:0] dec;
	logic [6:0] clamped;
	// typed decimal value and clamp to the loop range
	assign dec = {6'h00, val[11:8]} * DEC_HUND
		+ {6'h00, val[7:4]} * DEC_TEN + {6'h00, val[3:0]};
	assign clamped = (dec == 10'h000) ? FIRST_ADDR :
		(dec > {3'h0, count_i}) ? count_i : dec[6:0];

	// digit stack, newest digit in the low nibble
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			val <= 12'h000;
			digits_o <= 2'h0;
			sel_valid_o <= 1'b0;
			sel_o <= FIRST_ADDR;
		end else begin
			sel_valid_o <= 1'b0;
			if (!enable_i) begin
				val <= 12'h000;
				digits_o <= 2'h0;
			end else if (confirm_i && digits_o != 2'h0) begin
				sel_valid_o <= 1'b1;
				sel_o <= clamped;
				val <= 12'h000;
				digits_o <= 2'h0;
			end else if (clear_i && digits_o != 2'h0) begin
				val <= {4'h0, val[11:4]};
				digits_o <= digits_o - 2'h1;
			end else if (push_i && digits_o < GOTO_DIGITS
					&& digit_i <= DIGIT_MAX) begin
				val <= {val[7:0], digit_i};
				digits_o <= digits_o + 2'h1;
			end
		end
	end
endmodule

//--- hw/loop_cfg_pkg.sv
package loop_cfg_pkg;
	// register byte offsets
	localparam logic [7:0] REG_LOOP = 8'h00;
	localparam logic [7:0] REG_KEY = 8'h04;
	localparam logic [7:0] REG_UI = 8'h08;
	localparam logic [7:0] REG_DEV = 8'h0c;
	localparam logic [7:0] REG_OUT = 8'h10;
	localparam logic [7:0] REG_DELAY = 8'h14;
	localparam logic [7:0] REG_WIDTH = 8'h18;
	localparam logic [7:0] REG_OSTAT = 8'h1c;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// loop limits and address entry
	localparam logic [6:0] MAX_DEVICES = 7'h7d;
	localparam logic [6:0] GOTO_MIN = 7'h07;
	localparam logic [1:0] GOTO_DIGITS = 2'h3;
	localparam logic [3:0] DIGIT_MAX = 4'h9;
	localparam logic [9:0] DEC_HUND = 10'h064;
	localparam logic [9:0] DEC_TEN = 10'h00a;
	localparam logic [6:0] FIRST_ADDR = 7'h01;
	// key register fields
	localparam int KEY_DIG_LSB = 0;
	localparam int KEY_DIG_MSB = 3;
	localparam int KEY_PUSH = 4;
	localparam int KEY_CLEAR = 5;
	localparam int KEY_CONFIRM = 6;
	localparam int KEY_UP = 7;
	localparam int KEY_DOWN = 8;
	localparam int KEY_STATUS = 9;
	localparam int KEY_ADDRMODE = 10;
	localparam int KEY_PARAM = 11;
	localparam int KEY_PSEL_LSB = 12;
	localparam int KEY_PSEL_MSB = 13;
	localparam logic [1:0] PS_STATUS = 2'h0;
	localparam logic [1:0] PS_CLASS = 2'h1;
	localparam logic [1:0] PS_INPUT = 2'h2;
	localparam logic [1:0] PS_RELEASE = 2'h3;
	// per-device word fields
	localparam int DEV_W = 7;
	localparam int DV_ON = 0;
	localparam int DV_CLS_LSB = 1;
	localparam int DV_CLS_MSB = 2;
	localparam int DV_TYP_LSB = 3;
	localparam int DV_TYP_MSB = 4;
	localparam int DV_INP = 5;
	localparam int DV_REL = 6;
	localparam logic [DEV_W-1:0] DEV_RESET = 7'h01;
	typedef enum logic [1:0] {TYPE_PLAIN, TYPE_CLASSED, TYPE_INPUT, TYPE_IO}
		dev_type_e;
	// loop and output register fields
	localparam int LOOP_ON = 0;
	localparam int LOOP_MANUAL = 1;
	localparam int CNT_LSB = 8;
	localparam int CNT_MSB = 15;
	localparam int OUT_MODE_MSB = 3;
	localparam int OUT_ACT_HIGH = 4;
	localparam int OUT_RELEASE = 5;
	localparam logic [3:0] MODE_FIRST = 4'h1;
	localparam logic [3:0] MODE_LAST = 4'h8;
	localparam logic [31:0] DELAY_RESET = 32'h0000_0400;
	localparam logic [31:0] WIDTH_RESET = 32'h0000_0100;
	localparam logic [31:0] ONE_CYCLE = 32'h0000_0001;
endpackage

//--- hw/loop_device_output_config.sv
// Summary of operation
// - change key toggles loop status and addressing
// - device count limited to 0 through 125
// - empty loop: notice, no device actions
// - scrolling only with more than one device
// - address entry only above seven devices
// - up to three digits, clear drops last
// - typed zero selects address one
// - too large address selects highest device
// - selection clears digits, closes entry field
// - change key steps parameter to next value
// - class only for classed types; status always
// - input module: monitor or input, release reset
// - eight output modes numbered one to eight
// - continuous: held until reset or switch-off
// - delayed: wait interval, then assert output
// - inverted: energised in duty, released active
// - pulse ends by itself after width
// - delayed pulse: one pulse per activation
// - pulse train until reset or switch-off
// - delayed train starts after the delay
// - input activation level low or high
`timescale 1ns/1ns
module loop_device_output_config import loop_cfg_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic panel_activate_i,
	input wire logic panel_switch_off_i,
	input wire logic panel_reset_i,
	input wire logic sense_in_i,
	output logic input_report_o,
	output logic relay_o,
	output logic oc_drive_o
);
	logic aw_held, w_held;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic aw_take, w_take, aw_have, w_have, do_write;
	logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
	logic [7:0] wa;
	logic [31:0] wd, ws_mask, kd, rd_word;
	logic wa_map, ra_map, ar_take;
	logic loop_on, addr_manual;
	logic [6:0] dev_count, sel;
	logic [3:0] out_mode;
	logic act_high, release_rst;
	logic [31:0] delay_q, width_q, delay_new, width_new;
	logic [DEV_W-1:0] dev_mem [0:127];
	logic [DEV_W-1:0] cur_dev, next_dev;
	logic kw, k_up, k_down, k_param, dev_type_wr, dev_wr;
	logic ui_nodev, ui_scroll, ui_goto;
	logic [1:0] goto_cnt;
	logic goto_valid;
	logic [6:0] goto_sel;
	logic [3:0] sync1, sync2;
	logic in_active, in_prev, act_prev;
	// duty levels of the synchronised pins: sense rests high by default
	localparam logic [3:0] PIN_IDLE = 4'h8;
	logic fire, cancel, out_act, out_busy, out_inv, cls_ok;

	// write channel handshake, address and data taken in either order
	assign aw_take = s_axi_awready_o & s_axi_awvalid_i;
	assign w_take = s_axi_wready_o & s_axi_wvalid_i;
	assign aw_have = aw_held | aw_take;
	assign w_have = w_held | w_take;
	assign do_write = aw_have & w_have;
	assign next_aw_held = aw_have & ~do_write;
	assign next_w_held = w_have & ~do_write;
	assign next_bvalid = do_write | (s_axi_bvalid_o & ~s_axi_bready_i);
	assign wa = aw_take ? s_axi_awaddr_i : awaddr_q;
	assign wd = w_take ? s_axi_wdata_i : wdata_q;
	assign ws_mask = w_take ?
		{{8{s_axi_wstrb_i[3]}}, {8{s_axi_wstrb_i[2]}},
		{8{s_axi_wstrb_i[1]}}, {8{s_axi_wstrb_i[0]}}} :
		{{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
		{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	assign kd = wd & ws_mask;
	assign wa_map = (wa == REG_LOOP) | (wa == REG_KEY) | (wa == REG_UI)
		| (wa == REG_DEV) | (wa == REG_OUT) | (wa == REG_DELAY)
		| (wa == REG_WIDTH) | (wa == REG_OSTAT);

	// write channel state
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			if (aw_take) awaddr_q <= s_axi_awaddr_i;
			if (w_take) wdata_q <= s_axi_wdata_i;
			if (w_take) wstrb_q <= s_axi_wstrb_i;
			s_axi_awready_o <= ~next_aw_held & ~next_bvalid;
			s_axi_wready_o <= ~next_w_held & ~next_bvalid;
			s_axi_bvalid_o <= next_bvalid;
			if (do_write) s_axi_bresp_o <= wa_map ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// key register strobes, one cycle wide
	assign kw = do_write & (wa == REG_KEY);
	assign k_up = kw & kd[KEY_UP] & ui_scroll;
	assign k_down = kw & kd[KEY_DOWN] & ui_scroll;
	assign k_param = kw & kd[KEY_PARAM] & ~ui_nodev;
	assign dev_type_wr = do_write & (wa == REG_DEV) & ~ui_nodev;
	assign dev_wr = k_param | dev_type_wr;
	assign ui_nodev = (dev_count == 7'h00);
	assign ui_scroll = (dev_count > FIRST_ADDR);
	assign ui_goto = (dev_count > GOTO_MIN);
	assign delay_new = (delay_q & ~ws_mask) | kd;
	assign width_new = (width_q & ~ws_mask) | kd;

	// loop settings, output configuration and selection
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			loop_on <= 1'b0;
			addr_manual <= 1'b0;
			dev_count <= 7'h00;
			sel <= FIRST_ADDR;
			out_mode <= MODE_FIRST;
			act_high <= 1'b0;
			release_rst <= 1'b0;
			delay_q <= DELAY_RESET;
			width_q <= WIDTH_RESET;
		end else begin
			if (kw && kd[KEY_STATUS]) loop_on <= ~loop_on;
			if (kw && kd[KEY_ADDRMODE]) addr_manual <= ~addr_manual;
			if (do_write && wa == REG_LOOP && ws_mask[CNT_LSB]
					&& kd[CNT_MSB:CNT_LSB] <= {1'b0, MAX_DEVICES}) begin
				dev_count <= kd[CNT_MSB-1:CNT_LSB];
				sel <= FIRST_ADDR;
			end else if (goto_valid) begin
				sel <= goto_sel;
			end else if (k_up) begin
				sel <= (sel == dev_count) ? FIRST_ADDR : sel + 7'h01;
			end else if (k_down) begin
				sel <= (sel == FIRST_ADDR) ? dev_count : sel - 7'h01;
			end
			if (do_write && wa == REG_OUT && ws_mask[0]) begin
				if (kd[OUT_MODE_MSB:0] >= MODE_FIRST
						&& kd[OUT_MODE_MSB:0] <= MODE_LAST)
					out_mode <= kd[OUT_MODE_MSB:0];
				act_high <= kd[OUT_ACT_HIGH];
				release_rst <= kd[OUT_RELEASE];
			end
			if (do_write && wa == REG_DELAY && delay_new != 32'h0000_0000)
				delay_q <= delay_new;
			if (do_write && wa == REG_WIDTH && width_new != 32'h0000_0000)
				width_q <= width_new;
		end
	end

	// parameter change on the selected device
	assign cur_dev = dev_mem[sel];
	assign cls_ok = (cur_dev[DV_TYP_MSB:DV_TYP_LSB] == TYPE_CLASSED);
	always_comb begin
		next_dev = cur_dev;
		if (dev_type_wr) begin
			next_dev[DV_TYP_MSB:DV_TYP_LSB] = kd[DV_TYP_MSB:DV_TYP_LSB];
		end else begin
			case (kd[KEY_PSEL_MSB:KEY_PSEL_LSB])
			PS_STATUS: next_dev[DV_ON] = ~cur_dev[DV_ON];
			PS_CLASS: begin
				if (cls_ok)
					next_dev[DV_CLS_MSB:DV_CLS_LSB] =
						cur_dev[DV_CLS_MSB:DV_CLS_LSB] + 2'h1;
			end
			PS_INPUT: begin
				if (cur_dev[DV_TYP_MSB:DV_TYP_LSB] == TYPE_INPUT)
					next_dev[DV_INP] = ~cur_dev[DV_INP];
			end
			PS_RELEASE: begin
				if (cur_dev[DV_TYP_MSB:DV_TYP_LSB] == TYPE_INPUT
						&& cur_dev[DV_INP])
					next_dev[DV_REL] = ~cur_dev[DV_REL];
			end
			default: next_dev = cur_dev;
			endcase
		end
	end

	// per-device parameter words
	genvar gi;
	generate
		for (gi = 0; gi < 128; gi++) begin : g_dev
			always_ff @(posedge ref_clk_i or posedge rst_i) begin
				if (rst_i)
					dev_mem[gi] <= DEV_RESET;
				else if (dev_wr && sel == 7'(gi))
					dev_mem[gi] <= next_dev;
			end
		end
	endgenerate

	goto_entry u_goto (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.enable_i(ui_goto),
		.digit_i(kd[KEY_DIG_MSB:KEY_DIG_LSB]),
		.push_i(kw & kd[KEY_PUSH]),
		.clear_i(kw & kd[KEY_CLEAR]),
		.confirm_i(kw & kd[KEY_CONFIRM]),
		.count_i(dev_count),
		.digits_o(goto_cnt),
		.sel_valid_o(goto_valid),
		.sel_o(goto_sel)
	);

	// pin synchronisers, then edge detection on the second stage
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1 <= PIN_IDLE; // no false input edge after reset
			sync2 <= PIN_IDLE;
			in_prev <= 1'b0;
			act_prev <= 1'b0;
		end else begin
			sync1 <= {sense_in_i, panel_reset_i, panel_switch_off_i,
				panel_activate_i};
			sync2 <= sync1;
			in_prev <= in_active;
			act_prev <= sync2[0];
		end
	end
	assign in_active = act_high ? sync2[3] : ~sync2[3];
	assign fire = (sync2[0] & ~act_prev) | (in_active & ~in_prev);
	assign cancel = sync2[1] | sync2[2]
		| (release_rst & in_prev & ~in_active);
	assign out_inv = (out_mode == 4'h3) | (out_mode == 4'h4);

	out_timer u_timer (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.mode_idx_i(3'(out_mode - MODE_FIRST)),
		.delay_i(delay_q),
		.width_i(width_q),
		.fire_i(fire),
		.cancel_i(cancel),
		.act_o(out_act),
		.busy_o(out_busy)
	);

	// drive levels: inverted modes energise in duty
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			relay_o <= 1'b0;
			oc_drive_o <= 1'b0;
			input_report_o <= 1'b0;
		end else begin
			relay_o <= out_inv ? ~out_act : out_act;
			oc_drive_o <= out_inv ? ~out_act : out_act;
			input_report_o <= in_active;
		end
	end

	// read decode
	assign ra_map = (s_axi_araddr_i == REG_LOOP) | (s_axi_araddr_i == REG_KEY)
		| (s_axi_araddr_i == REG_UI) | (s_axi_araddr_i == REG_DEV)
		| (s_axi_araddr_i == REG_OUT) | (s_axi_araddr_i == REG_DELAY)
		| (s_axi_araddr_i == REG_WIDTH) | (s_axi_araddr_i == REG_OSTAT);
	assign rd_word =
		(s_axi_araddr_i == REG_LOOP) ? {16'h0000, 1'b0, dev_count, 6'h00,
			addr_manual, loop_on} :
		(s_axi_araddr_i == REG_UI) ? {9'h000, sel, 10'h000, goto_cnt,
			(goto_cnt != 2'h0), ui_goto, ui_scroll, ui_nodev} :
		(s_axi_araddr_i == REG_DEV) ? {25'h0000000, cur_dev[DV_REL:DV_TYP_LSB],
			cur_dev[DV_CLS_MSB:DV_CLS_LSB] & {2{cls_ok}}, cur_dev[DV_ON]} :
		(s_axi_araddr_i == REG_OUT) ? {26'h0000000, release_rst, act_high,
			out_mode} :
		(s_axi_araddr_i == REG_DELAY) ? delay_q :
		(s_axi_araddr_i == REG_WIDTH) ? width_q :
		(s_axi_araddr_i == REG_OSTAT) ? {29'h00000000, in_active, out_busy,
			out_act} : 32'h0000_0000;
	assign ar_take = s_axi_arready_o & s_axi_arvalid_i;
	assign next_rvalid = ar_take | (s_axi_rvalid_o & ~s_axi_rready_i);

	// read channel
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0000_0000;
			s_axi_rresp_o <= RESP_OKAY;
		end else begin
			s_axi_arready_o <= ~next_rvalid;
			s_axi_rvalid_o <= next_rvalid;
			if (ar_take) s_axi_rdata_o <= rd_word;
			if (ar_take) s_axi_rresp_o <= ra_map ? RESP_OKAY : RESP_SLVERR;
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	AST_TOGGLE: assert property ((kw && kd[KEY_STATUS]) |=>
		loop_on != $past(loop_on)) else $error("status did not toggle");
	AST_COUNT_MAX: assert property (dev_count <= MAX_DEVICES)
		else $error("device count above limit");
	AST_NODEV: assert property ((ui_nodev && kw) |=>
		$stable(sel) && $stable(cur_dev)) else $error("action on empty loop");
	AST_SCROLL: assert property ((dev_count <= FIRST_ADDR && kw
		&& !goto_valid) |=> $stable(sel)) else $error("scroll with one device");
	AST_GOTO_OFF: assert property (!ui_goto |=> goto_cnt == 2'h0)
		else $error("entry field open with few devices");
	AST_DIGITS: assert property (goto_cnt <= GOTO_DIGITS)
		else $error("more than three digits");
	AST_ZERO: assert property (goto_valid |-> goto_sel >= FIRST_ADDR)
		else $error("selected address zero");
	AST_HIGH: assert property (goto_valid |-> goto_sel <= dev_count)
		else $error("selected address past loop end");
	AST_CLEAR: assert property (goto_valid |-> goto_cnt == 2'h0
		##1 sel == $past(goto_sel)) else $error("entry not cleared");
	AST_CANCEL: assert property (cancel |-> ##2
		relay_o == $past(out_inv)) else $error("cancel left output active");
	AST_INV_DUTY: assert property ((out_inv && !out_act) |=>
		relay_o && oc_drive_o) else $error("inverted output not energised");
	AST_PULSE_AUTO: assert property (($rose(out_act)
		&& out_mode == 4'h5 && $past(width_q) == 32'h0000_0002)
		##1 $stable(out_mode) |=> !out_act) else $error("pulse did not end");
	COV_GOTO: cover property (goto_valid && goto_sel == dev_count);
	COV_TRAIN: cover property ((out_mode == 4'h7) && $rose(out_act));
	COV_DELAY_PULSE: cover property ((out_mode == 4'h6) && $fell(out_act));
	COV_PARAM: cover property (k_param && cls_ok);
endmodule

//--- hw/out_timer.sv
`timescale 1ns/1ns
module out_timer import loop_cfg_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [2:0] mode_idx_i,
	input wire logic [31:0] delay_i,
	input wire logic [31:0] width_i,
	input wire logic fire_i,
	input wire logic cancel_i,
	output logic act_o,
	output logic busy_o
);
	typedef enum logic [1:0] {T_IDLE, T_WAIT, T_ON, T_GAP} tstate_e;
	tstate_e state;
	logic [31:0] cnt;
	logic delayed, pulsed, train;
	// even mode numbers delay, modes 5..8 pulse, 7 and 8 repeat
	assign delayed = mode_idx_i[0];
	assign pulsed = mode_idx_i[2];
	assign train = mode_idx_i[2] & mode_idx_i[1];
	assign act_o = (state == T_ON);
	assign busy_o = (state != T_IDLE);

	// sequencer counting delay and width in clock cycles
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= T_IDLE;
			cnt <= 32'h0000_0000;
		end else if (cancel_i) begin
			state <= T_IDLE;
		end else begin
			case (state)
			T_IDLE: begin
				if (fire_i && delayed) begin
					state <= T_WAIT;
					cnt <= delay_i - ONE_CYCLE;
				end else if (fire_i) begin
					state <= T_ON;
					cnt <= width_i - ONE_CYCLE;
				end
			end
			T_WAIT: begin
				if (cnt == 32'h0000_0000) begin
					state <= T_ON;
					cnt <= width_i - ONE_CYCLE;
				end else begin
					cnt <= cnt - ONE_CYCLE;
				end
			end
			T_ON: begin
				if (pulsed && cnt == 32'h0000_0000) begin
					// single pulse ends alone, train gaps
					state <= train ? T_GAP : T_IDLE;
					cnt <= width_i - ONE_CYCLE;
				end else if (pulsed) begin
					cnt <= cnt - ONE_CYCLE;
				end
			end
			T_GAP: begin
				if (cnt == 32'h0000_0000) begin
					state <= T_ON;
					cnt <= width_i - ONE_CYCLE;
				end else begin
					cnt <= cnt - ONE_CYCLE;
				end
			end
			default: state <= T_IDLE;
			endcase
		end
	end
endmodule

//--- testbench/loop_device_output_config_bench.sv
`timescale 1ns/1ns
module loop_device_output_config_bench import loop_cfg_pkg::*;;
	logic ref_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, ui;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic act, soff, prst, sense_in, report, relay, oc;
	logic act_go, stop_go, stop_sw, sense_lvl;
	logic [7:0] cnts [5] = '{8'h0, 8'h1, 8'h2, 8'h7, 8'h8};
	int mismatches, checks, base;

	loop_device_output_config u_dut (
		.ref_clk_i(ref_clk),
		.rst_i(rst),
		.s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb),
		.s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr),
		.s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready),
		.panel_activate_i(act),
		.panel_switch_off_i(soff),
		.panel_reset_i(prst),
		.sense_in_i(sense_in),
		.input_report_o(report),
		.relay_o(relay),
		.oc_drive_o(oc)
	);
	panel_model u_panel (
		.ref_clk_i(ref_clk),
		.act_go_i(act_go),
		.stop_go_i(stop_go),
		.stop_sw_i(stop_sw),
		.sense_lvl_i(sense_lvl),
		.panel_activate_o(act),
		.panel_switch_off_o(soff),
		.panel_reset_o(prst),
		.sense_in_o(sense_in)
	);

	// 125 mhz clock
	always #4 ref_clk = ~ref_clk;

	task automatic chk(input string nm, input logic [63:0] e, g);
		checks++;
		if (e !== g) begin
			mismatches++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask

	// bus write: valids held until taken, bready until bvalid
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		chk($sformatf("bresp %h", a), er, bresp);
	endtask

	// bus read: arvalid until taken, rready until rvalid
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge ref_clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		chk($sformatf("rdata %h", a), {er, e}, {rresp, rdata});
	endtask

	task automatic key(input logic [31:0] d);
		wr(REG_KEY, d, RESP_OKAY);
	endtask

	// one activation, sampled output wave, then cancel
	task automatic run_mode(input logic [3:0] m);
		logic [39:0] seen, exp;
		logic inv;
		int s;
		inv = (m == 4'h3) || (m == 4'h4);
		wr(REG_OUT, {28'h0, m}, RESP_OKAY);
		repeat (8) @(posedge ref_clk);
		act_go <= 1'b1;
		@(posedge ref_clk);
		act_go <= 1'b0;
		for (int i = 0; i < 40; i++) begin
			@(posedge ref_clk);
			seen[i] = relay ^ inv;
			if (seen[i] === 1'b1 && base == 40) base = i;
		end
		s = base + (m[0] ? 0 : 3);
		for (int i = 0; i < 40; i++)
			exp[i] = (i >= s) && (m < 4'h5 ||
				(m < 4'h7 ? i - s < 2 : (i - s) % 4 < 2));
		chk("wave", exp, seen);
		chk("oc", exp[39] ^ inv, oc);
		stop_sw <= m[0];
		stop_go <= 1'b1;
		@(posedge ref_clk);
		stop_go <= 1'b0;
		repeat (10) @(posedge ref_clk);
		chk("duty", inv, relay);
		rd(REG_OSTAT, 32'h0, RESP_OKAY);
		$display("test mode %0d done", m);
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// watchdog
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		summarize();
	end

	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		{awvalid, wvalid, arvalid} = '0;
		{bready, rready} = 2'h3;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		{act_go, stop_go, stop_sw} = '0;
		sense_lvl = 1'b1;
		mismatches = 0;
		checks = 0;
		base = 40;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rd(REG_OUT, 32'h1, RESP_OKAY);
		rd(REG_DELAY, DELAY_RESET, RESP_OKAY);
		rd(REG_WIDTH, WIDTH_RESET, RESP_OKAY);
		rd(REG_UI, 32'h0001_0001, RESP_OKAY);
		wr(REG_DEV, 32'h08, RESP_OKAY);
		rd(REG_DEV, 32'h01, RESP_OKAY);
		wr(8'h20, 32'h1, RESP_SLVERR);
		rd(8'h20, 32'h0, RESP_SLVERR);
		$display("test reset done");
		key(32'h200);
		rd(REG_LOOP, 32'h1, RESP_OKAY);
		key(32'h400);
		key(32'h200);
		rd(REG_LOOP, 32'h2, RESP_OKAY);
		foreach (cnts[j]) begin
			wr(REG_LOOP, {16'h0, cnts[j], 8'h0}, RESP_OKAY);
			ui = {9'h0, FIRST_ADDR, 13'h0, cnts[j] > 8'h7,
				cnts[j] > 8'h1, cnts[j] == 8'h0};
			rd(REG_UI, ui, RESP_OKAY);
		end
		wr(REG_LOOP, 32'h7e00, RESP_OKAY);
		rd(REG_LOOP, 32'h0802, RESP_OKAY);
		wr(REG_LOOP, 32'h7d00, RESP_OKAY);
		rd(REG_LOOP, 32'h7d02, RESP_OKAY);
		$display("test loop done");
		for (int d = 1; d < 5; d++) key({28'h1, d[3:0]});
		rd(REG_UI, 32'h0001_003e, RESP_OKAY);
		key(32'h20);
		rd(REG_UI, 32'h0001_002e, RESP_OKAY);
		key(32'h40);
		rd(REG_UI, 32'h000c_0006, RESP_OKAY);
		key(32'h10);
		key(32'h40);
		rd(REG_UI, 32'h0001_0006, RESP_OKAY);
		repeat (3) key(32'h19);
		key(32'h40);
		rd(REG_UI, 32'h007d_0006, RESP_OKAY);
		key(32'h80);
		rd(REG_UI, 32'h0001_0006, RESP_OKAY);
		key(32'h100);
		rd(REG_UI, 32'h007d_0006, RESP_OKAY);
		$display("test entry done");
		wr(REG_DEV, 32'h08, RESP_OKAY);
		rd(REG_DEV, 32'h09, RESP_OKAY);
		key(32'h1800);
		rd(REG_DEV, 32'h0b, RESP_OKAY);
		key(32'h0800);
		rd(REG_DEV, 32'h0a, RESP_OKAY);
		wr(REG_DEV, 32'h0, RESP_OKAY);
		rd(REG_DEV, 32'h0, RESP_OKAY);
		wr(REG_DEV, 32'h10, RESP_OKAY);
		key(32'h2800);
		rd(REG_DEV, 32'h30, RESP_OKAY);
		key(32'h3820);
		rd(REG_DEV, 32'h70, RESP_OKAY);
		$display("test device done");
		wr(REG_DELAY, 32'h3, RESP_OKAY);
		wr(REG_WIDTH, 32'h2, RESP_OKAY);
		rd(REG_DELAY, 32'h3, RESP_OKAY);
		for (int m = 1; m < 9; m++) run_mode(m[3:0]);
		chk("base", 1, base < 30);
		sense_lvl <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk("low act", 1, report);
		sense_lvl <= 1'b1;
		repeat (6) @(posedge ref_clk);
		chk("low duty", 0, report);
		wr(REG_OUT, 32'h11, RESP_OKAY);
		repeat (6) @(posedge ref_clk);
		chk("high act", 1, report);
		$display("test input done");
		summarize();
	end
endmodule

//--- testbench/panel_model.sv
`timescale 1ns/1ns
// panel side: activation, cancel commands, input level
module panel_model (
	input wire logic ref_clk_i,
	input wire logic act_go_i,
	input wire logic stop_go_i,
	input wire logic stop_sw_i,
	input wire logic sense_lvl_i,
	output logic panel_activate_o,
	output logic panel_switch_off_o,
	output logic panel_reset_o,
	output logic sense_in_o
);
	logic [2:0] act_cnt = 3'h0;
	logic [2:0] stop_cnt = 3'h0;
	logic stop_kind = 1'b0;
	// one rising edge per request, level held four cycles
	always_ff @(posedge ref_clk_i) begin
		if (act_go_i)
			act_cnt <= 3'h4;
		else if (act_cnt != 3'h0)
			act_cnt <= act_cnt - 3'h1;
	end
	// switch-off or reset command, held four cycles
	always_ff @(posedge ref_clk_i) begin
		if (stop_go_i) begin
			stop_cnt <= 3'h4;
			stop_kind <= stop_sw_i;
		end else if (stop_cnt != 3'h0)
			stop_cnt <= stop_cnt - 3'h1;
	end
	// pin levels
	assign panel_activate_o = act_cnt != 3'h0;
	assign panel_switch_off_o = stop_cnt != 3'h0 && stop_kind;
	assign panel_reset_o = stop_cnt != 3'h0 && !stop_kind;
	assign sense_in_o = sense_lvl_i;
endmodule
